// ==== core/reset_strap_pkg.sv ====
/*
 * Shared constants and types for the reset strap capture and boot decode block.
 * Assumes one 100 MHz clock and a plain strobe register port on the host side.
 */
// Functional notes
// - latch all straps on power-on reset release
// - watchdog strap low disables, high enables
// - polarity strap sets host strobe active level
// - width strap: low 16-bit, high 8-bit
// - code 0000: host boot, PLL unused
// - host PLL codes set predivide/multiply/select, range
// - code 1000: software SPI boot, no PLL
// - hard reset line is open-drain both ways
// - hard reset alone keeps latched straps
// - PLL bypassed after power-on until software enables
package reset_strap_pkg;

	// ==========================================================
	// timing
	localparam int CLK_MHZ         = 100;   // core clock rate
	localparam int HARD_RESET_LINE_HOLD_NS  = 1000;  // least hard reset drive after power-on release
	localparam int HARD_RESET_LINE_HOLD_CYC = (HARD_RESET_LINE_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_W          = 8;     // width of the hold counter
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HARD_RESET_LINE_HOLD_CYC - 1);

	// ==========================================================
	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_STRAPS  = 8'h00;  // latched straps and status
	localparam logic [ADDR_W-1:0] REG_CLOCK   = 8'h04;  // decoded clock setup
	localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h08;  // software PLL enable

	// straps register fields
	localparam int ST_CODE_LSB = 0;   // 4-bit boot code
	localparam int ST_WDOG     = 4;
	localparam int ST_POL      = 5;
	localparam int ST_WIDTH    = 6;
	localparam int ST_VALID    = 7;
	localparam int ST_UNSUP    = 8;
	localparam int ST_SRC_LSB  = 9;   // 2-bit boot source
	localparam int ST_HRST     = 11;  // hard reset being driven
	// clock register fields
	localparam int CK_PREDIV_LSB = 0; // 2 bits
	localparam int CK_MULT_LSB   = 2; // 6 bits
	localparam int CK_SEL_LSB    = 8; // 2 bits
	localparam int CK_RANGE      = 10;
	localparam int CK_USES_PLL   = 11;
	localparam int CK_BYPASS     = 12;
	// control register fields
	localparam int CT_PLL_EN     = 0;

	// ==========================================================
	// boot codes
	localparam logic [3:0] BOOT_HOST_DIRECT = 4'h0;
	localparam logic [3:0] BOOT_HOST_P5     = 4'h5;
	localparam logic [3:0] BOOT_HOST_P2     = 4'h2;
	localparam logic [3:0] BOOT_HOST_P7     = 4'h7;
	localparam logic [3:0] BOOT_HOST_P4     = 4'h4;
	localparam logic [3:0] BOOT_SPI_SW      = 4'h8;

	// ==========================================================
	// types
	typedef enum logic [1:0] {SRC_HOST, SRC_SPI, SRC_NONE} bootSrc_t;

	typedef struct packed {
		logic [3:0] bootCode;    // boot select straps
		logic       wdog;        // watchdog enable strap
		logic       pol;         // host strobe polarity strap
		logic       width;       // host width strap
	} strapBundle_t;

	typedef struct packed {
		logic [1:0] predivide;
		logic [5:0] multiply;
		logic [1:0] clkSel;      // clock source select
		logic       range;       // pll range bit
		logic       usesPll;
	} clockCfg_t;

	typedef struct packed {
		bootSrc_t   src;
		clockCfg_t  cfg;
		logic       unsupported;
	} bootDecode_t;

	// ==========================================================
	// boot code table
	function automatic bootDecode_t decodeBoot(input logic [3:0] code);
		bootDecode_t d;
		d = '{src: SRC_NONE, cfg: '0, unsupported: 1'b1};
		case (code)
			BOOT_HOST_DIRECT: d = '{SRC_HOST, '{2'h0, 6'h00, 2'h0, 1'b0, 1'b0}, 1'b0};
			BOOT_HOST_P5:     d = '{SRC_HOST, '{2'h1, 6'h0C, 2'h3, 1'b1, 1'b1}, 1'b0};
			BOOT_HOST_P2:     d = '{SRC_HOST, '{2'h2, 6'h20, 2'h1, 1'b1, 1'b1}, 1'b0};
			BOOT_HOST_P7:     d = '{SRC_HOST, '{2'h3, 6'h0C, 2'h3, 1'b1, 1'b1}, 1'b0};
			BOOT_HOST_P4:     d = '{SRC_HOST, '{2'h2, 6'h0C, 2'h3, 1'b1, 1'b1}, 1'b0};
			BOOT_SPI_SW:      d = '{SRC_SPI,  '{2'h0, 6'h00, 2'h0, 1'b0, 1'b0}, 1'b0};
			default:          d = '{src: SRC_NONE, cfg: '0, unsupported: 1'b1};
		endcase
		return d;
	endfunction

endpackage

// ==== core/pin_sync.sv ====
/*
 * Three-stage synchroniser for pin levels with agreement filter.
 * Assumes pins are asynchronous to clk; output changes once stages two and three agree.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int              WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// pins and filtered levels
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [WIDTH-1:0] s1;      // first stage, read only by s2
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] stable;  // filtered level
	} syncState_t;

	syncState_t state_r;
	syncState_t state_nxt;
	logic [WIDTH-1:0] agree;       // stages two and three match

	// next state: a bit moves only when the last two stages agree
	always_comb begin
		state_nxt        = state_r;
		agree            = ~(state_r.s2 ^ state_r.s3);
		state_nxt.s1     = pinIn;
		state_nxt.s2     = state_r.s1;
		state_nxt.s3     = state_r.s2;
		state_nxt.stable = (state_r.s2 & agree) | (state_r.stable & ~agree);
	end

	// registers; reset loads constants only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign syncOut = state_r.stable;

endmodule // pin_sync
`default_nettype wire

// ==== core/reset_strap_boot_select.sv ====
/*
 * Reset strap capture, boot mode decode and open-drain hard reset driver.
 * Assumes strap and reset pins are asynchronous, a 100 MHz clk, and a
 * strobe-style register port whose master never needs a wait state.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_strap_boot_select (
	// clock and reset
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	// board pins
	input  wire logic                                powerOnResetIn_n,
	input  wire logic [3:0]                          bootSelectStraps,
	input  wire logic                                watchdogEnableStrap,
	input  wire logic                                hostStrobePolarityStrap,
	input  wire logic                                hostWidthStrap,
	// hard reset line, open-drain
	input  wire logic                                hardResetLineIn_n,
	output logic                                     hardResetLineOut,
	output logic                                     hardResetLineOe_n,
	// register port
	input  wire logic [reset_strap_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [reset_strap_pkg::DATA_W-1:0]  regWrData,
	input  wire logic                                regWrStrobe,
	input  wire logic                                regRdStrobe,
	output logic      [reset_strap_pkg::DATA_W-1:0]  regRdData,
	// decoded configuration
	output logic                                     strapsValid,
	output logic                                     watchdogEnable,
	output logic                                     hostStrobeActiveHigh,
	output logic                                     hostPort8Bit,
	output reset_strap_pkg::bootSrc_t                bootSource,
	output logic                                     bootCodeUnsupported,
	output reset_strap_pkg::clockCfg_t               clockConfig,
	output logic                                     pllBypass
);

	// ==========================================================
	// types and state
	typedef enum logic [1:0] {PH_POR, PH_HOLD, PH_RUN} phase_t;

	typedef struct packed {
		phase_t                                phase;
		logic [reset_strap_pkg::HOLD_W-1:0]    holdCount;   // hard reset stretch
		logic                                  porPrev;     // last filtered release level
		reset_strap_pkg::strapBundle_t         straps;      // latched straps
		logic                                  valid;       // straps captured once
		reset_strap_pkg::clockCfg_t            clock;       // decoded clock setup
		reset_strap_pkg::bootSrc_t             source;
		logic                                  unsupported;
		logic                                  pllEnable;   // software request
		logic                                  bypass;
		logic                                  hrstOe_n;
		logic                                  hrstOut;
		logic [reset_strap_pkg::DATA_W-1:0]    rdData;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	// filtered pins
	reset_strap_pkg::strapBundle_t strapSyncd;   // straps after filter
	logic                          porSyncd;     // high once power-on reset is released
	logic                          hrstSyncd_n;  // hard reset line level
	logic [1:0]                    ctlSyncd;     // {por, hard reset} filtered
	logic                          porRise;      // release edge of power-on reset
	reset_strap_pkg::bootDecode_t  decoded;      // table lookup of incoming code

	// ==========================================================
	// pin synchronisers
	// straps and reset pins share the same latency so the capture stays aligned
	pin_sync #(
		.WIDTH     (7),
		.RESET_VAL (7'h00)
	) strapSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.pinIn   ({bootSelectStraps, watchdogEnableStrap,
		           hostStrobePolarityStrap, hostWidthStrap}),
		.syncOut (strapSyncd)
	);

	// reset pins come up as asserted power-on, released hard reset line
	pin_sync #(
		.WIDTH     (2),
		.RESET_VAL (2'h1)
	) ctlSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.pinIn   ({powerOnResetIn_n, hardResetLineIn_n}),
		.syncOut (ctlSyncd)
	);

	assign porSyncd    = ctlSyncd[1];
	assign hrstSyncd_n = ctlSyncd[0];

	// ==========================================================
	// next state
	always_comb begin
		state_nxt         = state_r;
		porRise           = porSyncd & ~state_r.porPrev;
		decoded           = reset_strap_pkg::decodeBoot(strapSyncd.bootCode);
		state_nxt.porPrev = porSyncd;
		state_nxt.hrstOut = 1'b0;                     // open-drain: only ever pulls low
		state_nxt.rdData  = '0;

		// sequencing of the hard reset drive
		case (state_r.phase)
			PH_POR: begin
				// hold hard reset low while power-on reset is asserted
				state_nxt.hrstOe_n  = 1'b0;
				state_nxt.pllEnable = 1'b0;           // back to bypass on power-on
				if (porRise) begin
					// straps captured only here, never on hard reset
					state_nxt.straps      = strapSyncd;
					state_nxt.valid       = 1'b1;
					state_nxt.clock       = decoded.cfg;
					state_nxt.source      = decoded.src;
					state_nxt.unsupported = decoded.unsupported;
					state_nxt.holdCount   = '0;
					state_nxt.phase       = PH_HOLD;
				end
			end
			PH_HOLD: begin
				// stretch the hard reset past the release so others see it
				state_nxt.hrstOe_n  = 1'b0;
				state_nxt.holdCount = state_r.holdCount + 1'b1;
				if (!porSyncd) begin
					state_nxt.phase = PH_POR;
				end else if (state_r.holdCount == reset_strap_pkg::HOLD_LAST) begin
					state_nxt.hrstOe_n = 1'b1;        // let the pull-up take over
					state_nxt.phase    = PH_RUN;
				end
			end
			PH_RUN: begin
				state_nxt.hrstOe_n = 1'b1;
				if (!porSyncd) begin
					state_nxt.phase    = PH_POR;
					state_nxt.hrstOe_n = 1'b0;
				end else if (!hrstSyncd_n) begin
					// external hard reset: clocks fall back, straps stay
					state_nxt.pllEnable = 1'b0;
				end
			end
			default: begin
				state_nxt.phase    = PH_POR;
				state_nxt.hrstOe_n = 1'b0;
			end
		endcase

		// software write; ignored while any reset holds the block
		if (regWrStrobe && (state_r.phase == PH_RUN) && hrstSyncd_n && porSyncd) begin
			if (regAddr == reset_strap_pkg::REG_CONTROL) begin
				state_nxt.pllEnable = regWrData[reset_strap_pkg::CT_PLL_EN];
			end
		end

		// pll only leaves bypass when software asks and the mode uses it
		state_nxt.bypass = ~(state_nxt.pllEnable & state_nxt.clock.usesPll);

		// read data stands one cycle after the strobe; unmapped reads zero
		if (regRdStrobe) begin
			case (regAddr)
				reset_strap_pkg::REG_STRAPS: begin
					state_nxt.rdData[reset_strap_pkg::ST_CODE_LSB +: 4] = state_r.straps.bootCode;
					state_nxt.rdData[reset_strap_pkg::ST_WDOG]   = state_r.straps.wdog;
					state_nxt.rdData[reset_strap_pkg::ST_POL]    = state_r.straps.pol;
					state_nxt.rdData[reset_strap_pkg::ST_WIDTH]  = state_r.straps.width;
					state_nxt.rdData[reset_strap_pkg::ST_VALID]  = state_r.valid;
					state_nxt.rdData[reset_strap_pkg::ST_UNSUP]  = state_r.unsupported;
					state_nxt.rdData[reset_strap_pkg::ST_SRC_LSB +: 2] = state_r.source;
					state_nxt.rdData[reset_strap_pkg::ST_HRST]   = ~state_r.hrstOe_n;
				end
				reset_strap_pkg::REG_CLOCK: begin
					state_nxt.rdData[reset_strap_pkg::CK_PREDIV_LSB +: 2] = state_r.clock.predivide;
					state_nxt.rdData[reset_strap_pkg::CK_MULT_LSB +: 6]   = state_r.clock.multiply;
					state_nxt.rdData[reset_strap_pkg::CK_SEL_LSB +: 2]    = state_r.clock.clkSel;
					state_nxt.rdData[reset_strap_pkg::CK_RANGE]    = state_r.clock.range;
					state_nxt.rdData[reset_strap_pkg::CK_USES_PLL] = state_r.clock.usesPll;
					state_nxt.rdData[reset_strap_pkg::CK_BYPASS]   = state_r.bypass;
				end
				reset_strap_pkg::REG_CONTROL: begin
					state_nxt.rdData[reset_strap_pkg::CT_PLL_EN] = state_r.pllEnable;
				end
				default: begin
					state_nxt.rdData = '0;
				end
			endcase
		end
	end

	// ==========================================================
	// registers; reset leaves the line driven and the pll bypassed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '{
				phase:       PH_POR,
				holdCount:   '0,
				porPrev:     1'b0,
				straps:      '0,
				valid:       1'b0,
				clock:       '0,
				source:      reset_strap_pkg::SRC_NONE,
				unsupported: 1'b0,
				pllEnable:   1'b0,
				bypass:      1'b1,
				hrstOe_n:    1'b0,
				hrstOut:     1'b0,
				rdData:      '0
			};
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// outputs, all straight from flops
	assign hardResetLineOut     = state_r.hrstOut;
	assign hardResetLineOe_n    = state_r.hrstOe_n;
	assign regRdData            = state_r.rdData;
	assign strapsValid          = state_r.valid;
	assign watchdogEnable       = state_r.straps.wdog;
	assign hostStrobeActiveHigh = state_r.straps.pol;
	assign hostPort8Bit         = state_r.straps.width;
	assign bootSource           = state_r.source;
	assign bootCodeUnsupported  = state_r.unsupported;
	assign clockConfig          = state_r.clock;
	assign pllBypass            = state_r.bypass;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// release edge followed by the hard reset stretch
	sequence sRelease;
		porRise;
	endsequence
	sequence sDriveHeld;
		(!hardResetLineOe_n) [*8];
	endsequence

	a_strap_capture: assert property (sRelease |=> strapsValid &&
		{state_r.straps} == $past(strapSyncd))
		else $error("straps not latched on power-on release");

	a_wdog_strap: assert property (sRelease |=>
		watchdogEnable == $past(strapSyncd.wdog))
		else $error("watchdog enable not taken from strap");

	// the new level lands one edge after the release, so that cycle is left out
	a_wdog_steady: assert property (strapsValid && !porRise |=>
		$stable(watchdogEnable))
		else $error("watchdog enable moved without power-on release");

	a_strobe_pol: assert property (sRelease |=>
		hostStrobeActiveHigh == $past(strapSyncd.pol))
		else $error("strobe polarity not taken from strap");

	a_host_width: assert property (sRelease |=>
		hostPort8Bit == $past(strapSyncd.width))
		else $error("host width not taken from strap");

	a_direct_host: assert property (strapsValid &&
		state_r.straps.bootCode == reset_strap_pkg::BOOT_HOST_DIRECT |->
		bootSource == reset_strap_pkg::SRC_HOST && clockConfig.clkSel == 2'h0 &&
		!clockConfig.range && pllBypass)
		else $error("code 0000 decoded wrongly");

	a_pll_host: assert property (strapsValid &&
		state_r.straps.bootCode == reset_strap_pkg::BOOT_HOST_P2 |->
		clockConfig.predivide == 2'h2 && clockConfig.multiply == 6'h20 &&
		clockConfig.clkSel == 2'h1 && clockConfig.range)
		else $error("code 0010 decoded wrongly");

	a_spi_boot: assert property (strapsValid &&
		state_r.straps.bootCode == reset_strap_pkg::BOOT_SPI_SW |->
		bootSource == reset_strap_pkg::SRC_SPI && clockConfig.clkSel == 2'h0 &&
		!clockConfig.range && pllBypass)
		else $error("code 1000 decoded wrongly");

	a_open_drain: assert property (sRelease |=> sDriveHeld)
		else $error("hard reset line not held low after power-on release");

	// open-drain: the driven value is never high, only the enable moves
	a_drive_low: assert property (!hardResetLineOut)
		else $error("hard reset line driven high");

	a_hold_straps: assert property (!porRise |=> $stable(state_r.straps))
		else $error("straps changed without power-on release");

	a_pll_bypass: assert property (sRelease |=> pllBypass [*2])
		else $error("pll not bypassed after power-on");

	a_unsup_code: assert property (strapsValid &&
		state_r.straps.bootCode == 4'h3 |-> bootCodeUnsupported &&
		bootSource == reset_strap_pkg::SRC_NONE)
		else $error("reserved code not flagged");

	// read data stands for one cycle only, zero otherwise
	a_rd_zero: assert property (!$past(regRdStrobe) |-> regRdData == '0)
		else $error("read data present without a read strobe");

	// an external hard reset must not touch the decoded configuration
	a_hrst_keeps: assert property (state_r.phase == PH_RUN && !hrstSyncd_n |=>
		$stable(clockConfig) && $stable(bootSource))
		else $error("hard reset altered the latched configuration");

endmodule // reset_strap_boot_select
`default_nettype wire

// ==== verification/board_strap_model.sv ====
/*
 * Board-side model: strap levels, the power-on reset pin and an external
 * open-drain driver on the hard reset wire with its pull-up.
 * Assumes one clock shared with the block; levels change right after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module board_strap_model (
	// clock
	input  wire logic       clk,
	// power-on reset pin and straps
	output logic            powerOnResetIn_n,
	output logic [3:0]      bootSelectStraps,
	output logic            watchdogEnableStrap,
	output logic            hostStrobePolarityStrap,
	output logic            hostWidthStrap,
	// hard reset wire
	input  wire logic       hardResetLineOut,
	input  wire logic       hardResetLineOe_n,
	output logic            hardResetLineIn_n
);
	// ==========================================================
	// state
	logic extPull_r;  // external open-drain driver pulling the wire low

	initial begin
		powerOnResetIn_n        = 1'b0;
		bootSelectStraps        = 4'h0;
		watchdogEnableStrap     = 1'b0;
		hostStrobePolarityStrap = 1'b0;
		hostWidthStrap          = 1'b0;
		extPull_r               = 1'b0;
	end

	// ==========================================================
	// wire level: either party may only pull low, the pull-up wins otherwise
	assign hardResetLineIn_n = (!hardResetLineOe_n && !hardResetLineOut) || extPull_r
		? 1'b0 : 1'b1;

	// power cycle: straps settle well before release, then the board moves them
	// afterwards so that a design which keeps sampling shows it
	task automatic power_cycle(input logic [3:0] c, input logic w, input logic p,
		input logic h);
		@(posedge clk);
		powerOnResetIn_n        <= 1'b0;
		bootSelectStraps        <= c;
		watchdogEnableStrap     <= w;
		hostStrobePolarityStrap <= p;
		hostWidthStrap          <= h;
		repeat (8) @(posedge clk);
		powerOnResetIn_n <= 1'b1;
		repeat (2) @(posedge clk);
		bootSelectStraps        <= ~c;
		watchdogEnableStrap     <= ~w;
		hostStrobePolarityStrap <= ~p;
		hostWidthStrap          <= ~h;
	endtask

	// external hard reset pulse, open-drain only
	task automatic pulse_hard_reset(input int n);
		@(posedge clk);
		extPull_r <= 1'b1;
		repeat (n) @(posedge clk);
		extPull_r <= 1'b0;
	endtask
endmodule // board_strap_model
`default_nettype wire

// ==== verification/reset_strap_boot_select_tb.sv ====
/*
 * Self-checking bench for the strap capture and boot decode block.
 * Assumes the board model drives pins and this bench drives the register port.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_strap_boot_select_tb;
	// ==========================================================
	// signals
	logic                          clk, rst_n;
	logic [7:0]                    regAddr;
	logic [31:0]                   regWrData, regRdData;
	logic                          regWrStrobe, regRdStrobe, rdSeen;
	logic                          porPin_n, wdogS, polS, widthS, lineIn_n;
	logic                          lineOut, lineOe_n, valid, wdog, polHigh, port8;
	logic                          unsup, bypass;
	logic [3:0]                    straps;
	reset_strap_pkg::bootSrc_t     src;
	reset_strap_pkg::clockCfg_t    cfg;
	logic [31:0]                   expQ[$];       // expected read words, oldest first
	int                            nMismatch = 0;
	int                            numChecks = 0;
	int                            seed = 26519;

	// ==========================================================
	// clock and instances
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	board_strap_model board (.clk(clk), .powerOnResetIn_n(porPin_n),
		.bootSelectStraps(straps), .watchdogEnableStrap(wdogS),
		.hostStrobePolarityStrap(polS), .hostWidthStrap(widthS),
		.hardResetLineOut(lineOut), .hardResetLineOe_n(lineOe_n),
		.hardResetLineIn_n(lineIn_n));

	reset_strap_boot_select dut (.clk(clk), .rst_n(rst_n), .powerOnResetIn_n(porPin_n),
		.bootSelectStraps(straps), .watchdogEnableStrap(wdogS),
		.hostStrobePolarityStrap(polS), .hostWidthStrap(widthS),
		.hardResetLineIn_n(lineIn_n), .hardResetLineOut(lineOut),
		.hardResetLineOe_n(lineOe_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
		.strapsValid(valid), .watchdogEnable(wdog), .hostStrobeActiveHigh(polHigh),
		.hostPort8Bit(port8), .bootSource(src), .bootCodeUnsupported(unsup),
		.clockConfig(cfg), .pllBypass(bypass));

	// ==========================================================
	// comparison and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// read monitor: data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (rdSeen === 1'b1) begin
			if (expQ.size() == 0) begin
				check(regRdData, 32'hFFFF_FFFF);
			end else begin
				check(regRdData, expQ.pop_front());
			end
		end
		rdSeen <= regRdStrobe;
	end

	// ==========================================================
	// register port master
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWrStrobe <= 1'b1;
		regAddr     <= a;
		regWrData   <= d;
		@(posedge clk);
		regWrStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regRdStrobe <= 1'b1;
		regAddr     <= a;
		expQ.push_back(exp);
		@(posedge clk);
		regRdStrobe <= 1'b0;
	endtask

	// expected decode, worked out from the boot table
	task automatic decode_of(input logic [3:0] c, output reset_strap_pkg::bootSrc_t s,
		output reset_strap_pkg::clockCfg_t k, output logic u);
		s = reset_strap_pkg::SRC_HOST;
		u = 1'b0;
		k = '0;
		case (c)
			4'h0: k = '{2'h0, 6'h00, 2'h0, 1'b0, 1'b0};
			4'h5: k = '{2'h1, 6'h0C, 2'h3, 1'b1, 1'b1};
			4'h2: k = '{2'h2, 6'h20, 2'h1, 1'b1, 1'b1};
			4'h7: k = '{2'h3, 6'h0C, 2'h3, 1'b1, 1'b1};
			4'h4: k = '{2'h2, 6'h0C, 2'h3, 1'b1, 1'b1};
			4'h8: s = reset_strap_pkg::SRC_SPI;
			default: begin
				s = reset_strap_pkg::SRC_NONE;
				u = 1'b1;
			end
		endcase
	endtask

	// one full power cycle with one boot code, then software and hard reset
	task automatic run_code(input logic [3:0] c);
		logic [31:0]                r;
		logic                       w, p, h;
		reset_strap_pkg::bootSrc_t  s;
		reset_strap_pkg::clockCfg_t k;
		logic                       u;
		int                         n;
		r = $random(seed);
		{w, p, h} = r[2:0];
		decode_of(c, s, k, u);
		board.power_cycle(c, w, p, h);
		n = 2;
		while (lineOe_n !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, n >= 100 && n <= 112}, 32'h1);
		@(negedge clk);
		check({31'h0, valid}, 32'h1);
		check({31'h0, wdog}, {31'h0, w});
		check({31'h0, polHigh}, {31'h0, p});
		check({31'h0, port8}, {31'h0, h});
		check({30'h0, src}, {30'h0, s});
		check({31'h0, unsup}, {31'h0, u});
		check({21'h0, cfg}, {21'h0, k});
		check({31'h0, bypass}, 32'h1);
		rd(reset_strap_pkg::REG_STRAPS, {20'h0, 1'b0, s, u, 1'b1, h, p, w, c});
		rd(reset_strap_pkg::REG_CLOCK, {19'h0, 1'b1, k.usesPll, k.range, k.clkSel,
			k.multiply, k.predivide});
		rd(8'h0C, 32'h0);
		wr(reset_strap_pkg::REG_CONTROL, 32'h1);
		wr(reset_strap_pkg::REG_CLOCK, 32'h0);
		rd(reset_strap_pkg::REG_CONTROL, 32'h1);
		@(negedge clk);
		check({31'h0, bypass}, {31'h0, !k.usesPll});
		board.pulse_hard_reset(6);
		repeat (12) @(posedge clk);
		@(negedge clk);
		check({31'h0, bypass}, 32'h1);
		check({26'h0, valid, wdog, polHigh, port8, unsup, 1'b0},
			{26'h0, 1'b1, w, p, h, u, 1'b0});
		check({21'h0, cfg}, {21'h0, k});
		rd(reset_strap_pkg::REG_CONTROL, 32'h0);
		$display("test boot code %h done", c);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] r;
		rst_n       = 1'b0;
		regAddr     = 8'h00;
		regWrData   = 32'h0;
		regWrStrobe = 1'b0;
		regRdStrobe = 1'b0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		check({31'h0, lineOe_n}, 32'h0);
		check({31'h0, lineOut}, 32'h0);
		check({31'h0, valid}, 32'h0);
		@(posedge clk);
		rst_n <= 1'b1;
		run_code(4'h0);
		run_code(4'h5);
		run_code(4'h2);
		run_code(4'h7);
		run_code(4'h4);
		run_code(4'h8);
		run_code(4'h3);
		r = $random(seed);
		run_code(4'h9 + {2'h0, r[1:0]});
		repeat (4) @(posedge clk);
		final_report();
	end

	// watchdog well beyond the expected run of about 1200 cycles
	initial begin
		#100000;
		nMismatch++;
		$display("timeout at %0t", $time);
		final_report();
	end
endmodule // reset_strap_boot_select_tb
`default_nettype wire
